/* bsc_regs.svh */
// Cell positions of the boundary register, index 0 next to the serial output
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_LEN       112
`define BSC_PAR3      0
`define BSC_PAR2      1
`define BSC_PAR0      2
`define BSC_PAR1      3
`define BSC_STRAP     4
`define BSC_FAIL      5
`define BSC_CTL_FAIL  6
`define BSC_EMUL      7
`define BSC_BACKOFF   8
`define BSC_D_LO      9
`define BSC_CTL_DATA  17
`define BSC_D_HI      18
`define BSC_BTERM     42
`define BSC_READY     43
`define BSC_HOLD      44
`define BSC_GRANT     45
`define BSC_CTL_GRANT 46
`define BSC_ASTB      47
`define BSC_BE3       48
`define BSC_BLAST     52
`define BSC_DEN       53
`define BSC_WR        54
`define BSC_DIR       55
`define BSC_CTL_DIR   56
`define BSC_WAIT      57
`define BSC_STALL     58
`define BSC_DC        59
`define BSC_SUP       60
`define BSC_CTL_BUS   61
`define BSC_LOCK      62
`define BSC_REQUEST   63
`define BSC_A_HI      64
`define BSC_CTL_ADDR  80
`define BSC_A_LO      81
`define BSC_NMI       95
`define BSC_XINT7     96
`define BSC_RESET     104
`define BSC_CLK       105
`define BSC_CYC3      106
`define BSC_PERR      110
`define BSC_CTL_PERR  111
`define BSC_RST_CELLS 112'h0
`endif

/* bsc_pkg.sv */
// Pin and strobe groups of the boundary-scan chain
package bsc_pkg;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  data_parity;
        logic [31:2] addr;
        logic [3:0]  cycle_type;
        logic [3:0]  byte_lane_enable_n;
        logic        address_strobe_n;
        logic        burst_final_n;
        logic        data_enable_n;
        logic        write_not_read;
        logic        data_direction_n;
        logic        wait_state_n;
        logic        data_not_code;
        logic        supervisor_n;
        logic        atomic_lock_n;
        logic        grant_acknowledge;
        logic        bus_stall_out;
        logic        bus_request_out;
        logic        selftest_failure_n;
        logic        parity_error_out;
    } bsc_out_s;

    typedef struct packed {
        logic fail_grp;
        logic data_grp;
        logic grant_grp;
        logic bus_grp;
        logic dir_grp;
        logic addr_grp;
        logic parity_grp;
    } bsc_oe_s;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  data_parity;
        logic        test_strap;
        logic        emul_mode_n;
        logic        backoff_n;
        logic        burst_term_n;
        logic        ready_n;
        logic        hold_req;
        logic        nmi_n;
        logic [7:0]  ext_int_n;
        logic        reset_n;
        logic        clk_in;
    } bsc_in_s;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic extest;
    } bsc_tap_s;
endpackage

/* bsc_sync.sv */
// Two-flop synchroniser for levels from outside the ref_clk domain
`timescale 1ns/1ps
module bsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // First stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

/* bsc_chain.sv */
// Boundary register of 112 cells with pin muxing and tri-state control
// Operation
// - Chain of 112 cells; cell 1 next to serial output, cell 112 next to input.
// - Control cell 1 enables its outputs; 0 puts them in high impedance.
// - Every covered output is tri-statable through an enable cell.
// - One control cell, after failure cell, gates failure, stall and request.
// - One control cell between data bits 7 and 8 gates data and parity.
// - Dedicated control cell right after grant acknowledge gates it.
// - One control cell gates strobe, byte enables, burst, enable, wait, status, lock.
// - One control cell between address 16 and 15 gates address and cycle type.
// - Stall may assert without request; they are driven independently.
`timescale 1ns/1ps
`include "bsc_regs.svh"
module bsc_chain (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              tck,
    input  wire logic              tdi,
    input  wire bsc_pkg::bsc_tap_s tap,
    input  wire bsc_pkg::bsc_out_s core_out,
    input  wire bsc_pkg::bsc_oe_s  core_oe,
    input  wire bsc_pkg::bsc_in_s  pad_in,
    output bsc_pkg::bsc_out_s      pin_q,
    output bsc_pkg::bsc_oe_s       pin_oe_q,
    output logic                   tdo_q,
    output logic                   tdo_oe_q
);
    import bsc_pkg::*;

    localparam int SW = 2 + $bits(bsc_tap_s) + $bits(bsc_in_s);

    logic                tck_s;
    logic                tdi_s;
    bsc_tap_s            tap_s;
    bsc_in_s             pad_s;
    logic                tck_prev_q;
    logic                tck_prev_d;
    logic                tck_rise;
    logic                tck_fall;
    logic [`BSC_LEN-1:0] shift_q;
    logic [`BSC_LEN-1:0] shift_d;
    logic [`BSC_LEN-1:0] upd_q;
    logic [`BSC_LEN-1:0] upd_d;
    logic                tdo_d;
    logic                tdo_oe_d;
    bsc_out_s            pin_d;
    bsc_oe_s             pin_oe_d;

    // TCK, TDI and TAP strobes share one synchroniser so their delays match
    bsc_sync #(.WIDTH(SW)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({tck, tdi, tap, pad_in}),
        .sync_out ({tck_s, tdi_s, tap_s, pad_s})
    );

    function automatic logic [`BSC_LEN-1:0] pack_cells(bsc_out_s o, bsc_in_s i,
                                                     logic [`BSC_LEN-1:0] ctl);
        logic [`BSC_LEN-1:0] c;
        c = ctl;
        c[`BSC_PAR3]    = i.data_parity[3];
        c[`BSC_PAR2]    = i.data_parity[2];
        c[`BSC_PAR0]    = i.data_parity[0];
        c[`BSC_PAR1]    = i.data_parity[1];
        c[`BSC_STRAP]   = i.test_strap;
        c[`BSC_FAIL]    = o.selftest_failure_n;
        c[`BSC_EMUL]    = i.emul_mode_n;
        c[`BSC_BACKOFF] = i.backoff_n;
        for (int k = 0; k < 8; k++) begin
            c[`BSC_D_LO+k] = i.data[k];
        end
        for (int k = 8; k < 32; k++) begin
            c[`BSC_D_HI+k-8] = i.data[k];
        end
        c[`BSC_BTERM] = i.burst_term_n;
        c[`BSC_READY] = i.ready_n;
        c[`BSC_HOLD]  = i.hold_req;
        c[`BSC_GRANT] = o.grant_acknowledge;
        c[`BSC_ASTB]  = o.address_strobe_n;
        for (int k = 0; k < 4; k++) begin
            c[`BSC_BE3+3-k] = o.byte_lane_enable_n[k];
            c[`BSC_CYC3+3-k] = o.cycle_type[k];
        end
        c[`BSC_BLAST] = o.burst_final_n;
        c[`BSC_DEN]   = o.data_enable_n;
        c[`BSC_WR]    = o.write_not_read;
        c[`BSC_DIR]   = o.data_direction_n;
        c[`BSC_WAIT]  = o.wait_state_n;
        c[`BSC_STALL] = o.bus_stall_out;
        c[`BSC_DC]    = o.data_not_code;
        c[`BSC_SUP]   = o.supervisor_n;
        c[`BSC_LOCK]  = o.atomic_lock_n;
        c[`BSC_REQUEST] = o.bus_request_out;
        for (int k = 16; k < 32; k++) begin
            c[`BSC_A_HI+31-k] = o.addr[k];
        end
        for (int k = 2; k < 16; k++) begin
            c[`BSC_A_LO+15-k] = o.addr[k];
        end
        c[`BSC_NMI] = i.nmi_n;
        for (int k = 0; k < 8; k++) begin
            c[`BSC_XINT7+7-k] = i.ext_int_n[k];
        end
        c[`BSC_RESET] = i.reset_n;
        c[`BSC_CLK]   = i.clk_in;
        c[`BSC_PERR]  = o.parity_error_out;
        return c;
    endfunction

    function automatic bsc_out_s cells_to_out(logic [`BSC_LEN-1:0] c);
        bsc_out_s o;
        o = '0;
        o.data_parity = {c[`BSC_PAR3], c[`BSC_PAR2], c[`BSC_PAR1], c[`BSC_PAR0]};
        o.selftest_failure_n = c[`BSC_FAIL];
        for (int k = 0; k < 8; k++) begin
            o.data[k] = c[`BSC_D_LO+k];
        end
        for (int k = 8; k < 32; k++) begin
            o.data[k] = c[`BSC_D_HI+k-8];
        end
        o.grant_acknowledge = c[`BSC_GRANT];
        o.address_strobe_n  = c[`BSC_ASTB];
        for (int k = 0; k < 4; k++) begin
            o.byte_lane_enable_n[k] = c[`BSC_BE3+3-k];
            o.cycle_type[k]         = c[`BSC_CYC3+3-k];
        end
        o.burst_final_n    = c[`BSC_BLAST];
        o.data_enable_n    = c[`BSC_DEN];
        o.write_not_read   = c[`BSC_WR];
        o.data_direction_n = c[`BSC_DIR];
        o.wait_state_n     = c[`BSC_WAIT];
        o.bus_stall_out    = c[`BSC_STALL];
        o.data_not_code    = c[`BSC_DC];
        o.supervisor_n     = c[`BSC_SUP];
        o.atomic_lock_n    = c[`BSC_LOCK];
        o.bus_request_out  = c[`BSC_REQUEST];
        for (int k = 16; k < 32; k++) begin
            o.addr[k] = c[`BSC_A_HI+31-k];
        end
        for (int k = 2; k < 16; k++) begin
            o.addr[k] = c[`BSC_A_LO+15-k];
        end
        o.parity_error_out = c[`BSC_PERR];
        return o;
    endfunction

    // Edges of the sampled test clock; both flops see the same synchronised copy
    always_comb begin
        tck_prev_d = tck_s;
        tck_rise   = tck_s & ~tck_prev_q;
        tck_fall   = ~tck_s & tck_prev_q;
    end

    always_comb begin
        shift_d  = shift_q;
        upd_d    = upd_q;
        tdo_d    = tdo_q;
        tdo_oe_d = tdo_oe_q;
        if (tck_rise) begin
            if (tap_s.capture) begin
                shift_d = pack_cells(pin_q, pad_s, upd_q);
            end else if (tap_s.shift) begin
                shift_d = {tdi_s, shift_q[`BSC_LEN-1:1]};
            end
        end
        // Serial output moves on the falling edge so the far end samples it clean
        if (tck_fall) begin
            tdo_d    = shift_q[0];
            tdo_oe_d = tap_s.shift;
            if (tap_s.update) begin
                upd_d = shift_q;
            end
        end
    end

    // Pins follow the core unless external test drives them from the update stage
    always_comb begin
        if (tap_s.extest) begin
            pin_d               = cells_to_out(upd_q);
            pin_oe_d.fail_grp   = upd_q[`BSC_CTL_FAIL];
            pin_oe_d.data_grp   = upd_q[`BSC_CTL_DATA];
            pin_oe_d.grant_grp  = upd_q[`BSC_CTL_GRANT];
            pin_oe_d.bus_grp    = upd_q[`BSC_CTL_BUS];
            pin_oe_d.dir_grp    = upd_q[`BSC_CTL_DIR];
            pin_oe_d.addr_grp   = upd_q[`BSC_CTL_ADDR];
            pin_oe_d.parity_grp = upd_q[`BSC_CTL_PERR];
        end else begin
            pin_d    = core_out;
            pin_oe_d = core_oe;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tck_prev_q <= 1'h0;
            shift_q    <= `BSC_RST_CELLS;
            upd_q      <= `BSC_RST_CELLS;
            tdo_q      <= 1'h0;
            tdo_oe_q   <= 1'h0;
            pin_q      <= '0;
            pin_oe_q   <= '0;
        end else begin
            tck_prev_q <= tck_prev_d;
            shift_q    <= shift_d;
            upd_q      <= upd_d;
            tdo_q      <= tdo_d;
            tdo_oe_q   <= tdo_oe_d;
            pin_q      <= pin_d;
            pin_oe_q   <= pin_oe_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_shift_step;
        tck_rise && tap_s.shift && !tap_s.capture;
    endsequence

    sequence s_update_step;
        tck_fall && tap_s.update;
    endsequence

    AST_SHIFT_ORDER: assert property (s_shift_step |=>
        shift_q == {$past(tdi_s), $past(shift_q[`BSC_LEN-1:1])})
        else $error("shift did not move one cell toward serial output");
    AST_TDO_CELL1: assert property (tck_fall |=> tdo_q == $past(shift_q[0]))
        else $error("serial output is not cell 1");
    AST_CTL_ZERO: assert property ((tap_s.extest && !upd_q[`BSC_CTL_DATA])
        |=> !pin_oe_q.data_grp)
        else $error("data pins driven with control cell low");
    AST_NORMAL_OE: assert property (!tap_s.extest |=> pin_oe_q == $past(core_oe))
        else $error("enables do not follow core outside external test");
    AST_FAIL_GRP: assert property (tap_s.extest
        |=> pin_oe_q.fail_grp == $past(upd_q[`BSC_CTL_FAIL]))
        else $error("failure group enable wrong");
    AST_DATA_GRP: assert property (tap_s.extest
        |=> pin_oe_q.data_grp == $past(upd_q[`BSC_CTL_DATA]))
        else $error("data group enable wrong");
    AST_GRANT_GRP: assert property (tap_s.extest
        |=> pin_oe_q.grant_grp == $past(upd_q[`BSC_CTL_GRANT]))
        else $error("grant enable wrong");
    AST_BUS_GRP: assert property (tap_s.extest
        |=> pin_oe_q.bus_grp == $past(upd_q[`BSC_CTL_BUS]))
        else $error("bus control group enable wrong");
    AST_ADDR_GRP: assert property (tap_s.extest
        |=> pin_oe_q.addr_grp == $past(upd_q[`BSC_CTL_ADDR]))
        else $error("address group enable wrong");
    AST_STALL_FREE: assert property (!tap_s.extest |=>
        pin_q.bus_stall_out == $past(core_out.bus_stall_out)
        && pin_q.bus_request_out == $past(core_out.bus_request_out))
        else $error("stall or request not passed independently");
    AST_UPDATE_ONLY: assert property (!(tck_fall && tap_s.update) |=> $stable(upd_q))
        else $error("update stage changed without update");
    AST_UPDATE_LOAD: assert property (s_update_step |=> upd_q == $past(shift_q))
        else $error("update stage did not load shift stage");
endmodule

/* bsc_tap_model.sv */
// Test controller and bus arbiter model facing the boundary-scan chain
`timescale 1ns/1ps
module bsc_tap_model (
    input  wire logic         ref_clk,
    input  wire logic         tdo,
    input  wire logic         stall,
    input  wire logic         request,
    output logic              tck,
    output logic              tdi,
    output bsc_pkg::bsc_tap_s tap,
    output logic              bus_need,
    output logic              bus_urgent
);
    import bsc_pkg::*;
    // Stall can come without request, so an and would miss stalls
    assign bus_need = stall | request;
    assign bus_urgent = stall;
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        tap = '0;
    end
    // One 400 ns test clock; tdi for the next rise changes mid-low
    task automatic pulse(input logic b, output logic seen);
        @(negedge ref_clk) tck = 1'b1;
        repeat (4) @(negedge ref_clk);
        seen = tdo;
        tck = 1'b0;
        repeat (2) @(negedge ref_clk);
        tdi = b;
        @(negedge ref_clk);
    endtask
    task automatic scan(input logic [111:0] vin, output logic [111:0] vout);
        logic s;
        @(negedge ref_clk) tap.capture = 1'b1;
        pulse(vin[0], s);
        @(negedge ref_clk) tap.capture = 1'b0;
        tap.shift = 1'b1;
        for (int i = 0; i < 112; i++) begin
            pulse(i < 111 ? vin[i+1] : ~vin[i], s);
            vout[i] = s;
        end
        @(negedge ref_clk) tap.shift = 1'b0;
    endtask
    task automatic update();
        logic s;
        @(negedge ref_clk) tap.update = 1'b1;
        pulse(~tdi, s);
        @(negedge ref_clk) tap.update = 1'b0;
    endtask
    task automatic mode(input logic x);
        @(negedge ref_clk) tap.extest = x;
    endtask
endmodule

/* bsc_chain_bench.sv */
// Self-checking bench of the boundary-scan chain
`timescale 1ns/1ps
`include "bsc_regs.svh"
module bsc_chain_bench;
    import bsc_pkg::*;
    logic         ref_clk = 1'b0;
    logic         reset = 1'b1;
    logic         tck, tdi, tdo_q, tdo_oe_q, bus_need, bus_urgent;
    bsc_tap_s     tap;
    bsc_out_s     core_out, pin_q, ro;
    bsc_oe_s      core_oe, pin_oe_q, roe;
    bsc_in_s      pad_in, pv, pu;
    logic [31:0]  seed = 32'h10;
    logic [111:0] v, u, w, got;
    int           errors = 0;
    int           checks = 0;
    int           cycles = 0;
    always #25 ref_clk = ~ref_clk;
    bsc_chain dut (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tdi(tdi), .tap(tap),
        .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in), .pin_q(pin_q),
        .pin_oe_q(pin_oe_q), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q));
    bsc_tap_model tm (.ref_clk(ref_clk), .tdo(tdo_q), .stall(pin_q.bus_stall_out),
        .request(pin_q.bus_request_out), .tck(tck), .tdi(tdi), .tap(tap),
        .bus_need(bus_need), .bus_urgent(bus_urgent));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Cell image of the chain, index 0 next to the serial output
    function automatic logic [111:0] pack(bsc_out_s o, bsc_oe_s e, bsc_in_s p);
        logic [111:0] c;
        c = '0;
        c[8:0] = {p.backoff_n, p.emul_mode_n, e.fail_grp, o.selftest_failure_n,
            p.test_strap, p.data_parity[1], p.data_parity[0], p.data_parity[2],
            p.data_parity[3]};
        c[17] = e.data_grp;
        c[47:42] = {o.address_strobe_n, e.grant_grp, o.grant_acknowledge, p.hold_req,
            p.ready_n, p.burst_term_n};
        c[63:52] = {o.bus_request_out, o.atomic_lock_n, e.bus_grp, o.supervisor_n,
            o.data_not_code, o.bus_stall_out, o.wait_state_n, e.dir_grp,
            o.data_direction_n, o.write_not_read, o.data_enable_n, o.burst_final_n};
        c[80] = e.addr_grp;
        c[95] = p.nmi_n;
        c[105:104] = {p.clk_in, p.reset_n};
        c[111:110] = {e.parity_grp, o.parity_error_out};
        for (int i = 0; i < 32; i++) begin
            c[i < 8 ? `BSC_D_LO + i : `BSC_D_HI + i - 8] = p.data[i];
        end
        for (int i = 0; i < 16; i++) begin
            c[`BSC_A_HI + i] = o.addr[31 - i];
            if (i < 14) c[`BSC_A_LO + i] = o.addr[15 - i];
            if (i < 8) c[`BSC_XINT7 + i] = p.ext_int_n[7 - i];
            if (i < 4) begin
                c[`BSC_BE3 + i] = o.byte_lane_enable_n[3 - i];
                c[`BSC_CYC3 + i] = o.cycle_type[3 - i];
            end
        end
        return c;
    endfunction
    // Pins as seen in external test; data pads read back their driven value
    function automatic logic [111:0] seen_pins(bsc_in_s p);
        p.data = pin_q.data;
        p.data_parity = pin_q.data_parity;
        return pack(pin_q, pin_oe_q, p);
    endfunction
    task automatic roll();
        logic [95:0] r;
        r = {rnd(), rnd(), rnd()};
        ro = r[87:0];
        roe = r[94:88];
        r = {rnd(), rnd(), rnd()};
        pv = r[52:0];
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (!ok) begin
            errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Two full scans take about 1810 cycles; the ceiling leaves room for both
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        core_out = '0;
        core_oe = '0;
        pad_in = '0;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        chk(pin_oe_q === '0 && tdo_oe_q === 1'b0, "outputs not released");
        for (int i = 0; i < 20; i++) begin
            roll();
            if (i == 0) begin
                ro.bus_stall_out = 1'b1;
                ro.bus_request_out = 1'b0;
            end
            core_out = ro;
            core_oe = roe;
            @(negedge ref_clk);
            chk(pin_q === ro && pin_oe_q === roe, "functional pins");
            chk(bus_need === (ro.bus_stall_out | ro.bus_request_out), "bus need");
            chk(bus_urgent === ro.bus_stall_out, "bus urgency");
        end
        $display("Test functional path done");
        pad_in = pv;
        w = pack(core_out, '0, pad_in);
        roll();
        v = pack(ro, roe, pv);
        tm.scan(v, got);
        chk(got === w, "sampled chain");
        chk(tdo_oe_q === 1'b1, "serial output not enabled in shift");
        chk(pin_q === core_out && pin_oe_q === core_oe, "pins moved in scan");
        tm.update();
        tm.mode(1'b1);
        chk(tdo_oe_q === 1'b0, "serial output left enabled");
        repeat (4) @(negedge ref_clk);
        chk(seen_pins(pv) === v, "extest pins");
        $display("Test sample and extest done");
        w = pack(ro, roe, pad_in);
        u = v;
        pu = pv;
        roll();
        v = pack(ro, roe, pv);
        tm.scan(v, got);
        chk(got === w, "extest capture");
        chk(seen_pins(pu) === u, "pins changed before update");
        tm.update();
        repeat (2) @(negedge ref_clk);
        chk(seen_pins(pv) === v, "second update");
        $display("Test rescan done");
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(pin_oe_q === '0 && pin_q === '0, "pins kept after reset");
        $display("Test second reset done");
        end_sim();
    end
endmodule
